//--- shared/lqa_pkg.sv
// package for the link quality threshold access block
// assumes a 16-bit register port with one-cycle read latency
package lqa_pkg;

  // ==========================================================
  // register map
  localparam logic [4:0] LQA_ADDR_DATA     = 5'h1e;
  localparam logic [4:0] LQA_ADDR_VARIANCE = 5'h1f;
  localparam logic [4:0] LQA_ADDR_MAIN     = 5'h1d;

  // ==========================================================
  // data access register fields
  localparam int LQA_SAMPLE_BIT = 13;
  localparam int LQA_COMMIT_BIT = 12;
  localparam int LQA_PSEL_HI    = 11;
  localparam int LQA_PSEL_LO    = 9;
  localparam int LQA_TSEL_BIT   = 8;
  localparam int LQA_BYTE_HI    = 7;
  localparam int LQA_BYTE_LO    = 0;
  localparam logic [7:0] LQA_BYTE_RESET = 8'h80;

  // ==========================================================
  // variance register fields
  localparam int LQA_RESTART_VAR_BIT = 10;
  localparam int LQA_VAR_FLAG_BIT    = 1;

  // ==========================================================
  // threshold reset values: extremes disable the check
  localparam logic [7:0] LQA_LOW_RESET  = 8'h80;
  localparam logic [7:0] LQA_HIGH_RESET = 8'h7f;
  localparam logic [7:0] LQA_VAR_RESET  = 8'hff;

  localparam int LQA_NUM_PARAMS = 6;

  typedef enum logic [2:0] {
    LQA_P_EQUALIZER = 3'h0,
    LQA_P_GAIN      = 3'h1,
    LQA_P_BASELINE  = 3'h2,
    LQA_P_FREQ_OFS  = 3'h3,
    LQA_P_FREQ_CTL  = 3'h4,
    LQA_P_VARIANCE  = 3'h5
  } lqa_param_t;

  // live parameter values from the signal processor
  typedef struct packed {
    logic [7:0]  equalizer;
    logic [7:0]  gain;
    logic [7:0]  baseline;
    logic [7:0]  freq_ofs;
    logic [7:0]  freq_ctl;
    logic [31:0] variance;
  } lqa_params_t;

  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } lqa_bus_req_t;

endpackage : lqa_pkg

//--- hdl/lqa_thr_store.sv
// threshold storage: low/high byte per parameter, variance as two bytes
// assumes write requests come one cycle wide from the register logic
module lqa_thr_store
  import lqa_pkg::*;
(
  input  wire logic       core_clk_i,   // device clock
  input  wire logic       rstn_i,       // async reset, active low
  input  wire logic       wr_i,         // store request
  input  wire logic [2:0] psel_i,       // parameter choice
  input  wire logic       tsel_i,       // low/high choice
  input  wire logic [7:0] byte_i,       // byte to store
  output logic [7:0]      rd_byte_o,    // selected threshold
  output logic [95:0]     flat_o        // all thresholds, {hi,lo} per parameter
);

  typedef struct packed {
    logic [LQA_NUM_PARAMS-1:0][1:0][7:0] thr;
  } lqa_store_t;

  lqa_store_t st, next_st;

  function automatic logic [7:0] lqa_reset_byte(input int p, input int t);
    if (p == int'(LQA_P_VARIANCE)) return LQA_VAR_RESET;
    return (t == 0) ? LQA_LOW_RESET : LQA_HIGH_RESET;
  endfunction : lqa_reset_byte

  always_comb begin
    next_st = st;
    if (wr_i && (int'(psel_i) < LQA_NUM_PARAMS)) begin
      next_st.thr[psel_i][tsel_i] = byte_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int p = 0; p < LQA_NUM_PARAMS; p++) begin
        for (int t = 0; t < 2; t++) begin
          st.thr[p][t] <= lqa_reset_byte(p, t);
        end
      end
    end else begin
      st <= next_st;
    end
  end

  assign rd_byte_o = (int'(psel_i) < LQA_NUM_PARAMS) ? st.thr[psel_i][tsel_i] : 8'h00;
  assign flat_o    = st.thr;

endmodule : lqa_thr_store

//--- hdl/lqa_compare.sv
// threshold comparator: flags low and high crossings for five parameters, only the high crossing for variance
// assumes signed 8-bit parameters and an unsigned 16-bit variance high word
module lqa_compare
  import lqa_pkg::*;
(
  input  wire logic        core_clk_i,  // device clock
  input  wire logic        rstn_i,      // async reset, active low
  input  wire logic        active_i,    // monitor running
  input  lqa_params_t      params_i,    // live values
  input  wire logic [95:0] thr_i,       // thresholds
  output logic [9:0]       warn_o,      // {hi,lo} crossings, five parameters
  output logic             var_over_o   // variance above its high threshold
);

  typedef struct packed {
    logic [9:0] warn;
    logic       var_over;
  } lqa_cmp_t;

  lqa_cmp_t st, next_st;
  logic [4:0][7:0] vals;

  assign vals = {params_i.freq_ctl, params_i.freq_ofs, params_i.baseline,
                 params_i.gain, params_i.equalizer};

  always_comb begin
    next_st = '0;
    if (active_i) begin
      for (int p = 0; p < 5; p++) begin
        next_st.warn[2*p]   = $signed(vals[p]) < $signed(thr_i[16*p +: 8]);
        next_st.warn[2*p+1] = $signed(vals[p]) > $signed(thr_i[16*p+8 +: 8]);
      end
      next_st.var_over = params_i.variance[31:16] > thr_i[80 +: 16];
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign warn_o     = st.warn;
  assign var_over_o = st.var_over;

endmodule : lqa_compare

//--- hdl/lqa_access.sv
// link quality threshold access: data access and variance registers
// assumes the main monitor register, mask and config live elsewhere and
// arrive here as plain inputs; registers are reached over a strobe port
//
// Summary of operation
// - powered down blocks threshold writes
// - sample bit starts live value sampling
// - commit bit stores byte; reads zero
// - parameter choice selects one of six
// - same choice for sampling and thresholds
// - low/high choice picks low or high
// - variance uses bytes 23:16 and 31:24
// - data byte resets to 0x80
// - sample off reads selected threshold
// - sample on reads held sampled value
// - reserved bits read zero, ignore writes
// - violation raises interrupt when mask allows
// - variance read clears, does not re-arm
// - variance flag sets on high crossing
// - restart option resets processor on a new variance violation
// - signal detect option 0 drops link
// - monitor runs only enabled with link
// - main register read clears and re-arms
//
// The plain strobed port was left to the implementer.
module lqa_access
  import lqa_pkg::*;
(
  input  wire logic        core_clk_i,       // device clock, 100 MHz
  input  wire logic        rstn_i,           // async reset, active low
  input  wire logic [4:0]  addr_i,           // register address
  input  wire logic [15:0] wdata_i,          // write data
  input  wire logic        wr_i,             // write strobe
  input  wire logic        rd_i,             // read strobe
  output logic [15:0]      rdata_o,          // read data, cycle after rd_i
  input  wire logic        power_down_i,     // device powered down
  input  wire logic        monitor_enable_i, // main monitor enable
  input  wire logic        link_100_ok_i,    // valid 100 Mb link
  input  wire logic        signal_detect_option_i, // config option bit
  input  wire logic        irq_enable_i,     // mask enable for quality events
  input  lqa_params_t      params_i,         // live adapted parameters
  output logic [9:0]       main_warn_o,      // sticky warnings for main register
  output logic             irq_o,            // quality interrupt request
  output logic             dsp_restart_o,    // restart pulse to signal processor
  output logic             link_drop_o       // link status drop pulse
);

  // ==========================================================
  // state
  typedef struct packed {
    logic        sample_on;
    logic [2:0]  psel;
    logic        tsel;
    logic [7:0]  data_byte;
    logic [7:0]  sampled;
    logic        restart_var;
    logic        var_flag;
    logic [9:0]  main_warn;
    logic        armed;
    logic        irq;
    logic        restart;
    logic        drop;
    logic [15:0] rdata;
    logic        var_prev;
  } lqa_state_t;

  lqa_state_t st, next_st;

  logic        commit;
  logic [7:0]  thr_byte;
  logic [95:0] thr_flat;
  logic [9:0]  warn;
  logic        var_over;
  logic        active;
  logic        wr_data, wr_var, rd_data, rd_var, rd_main;

  function automatic logic [7:0] lqa_live_byte(input logic [2:0] sel, input lqa_params_t p,
                                               input logic hi);
    case (sel)
      LQA_P_EQUALIZER: return p.equalizer;
      LQA_P_GAIN:      return p.gain;
      LQA_P_BASELINE:  return p.baseline;
      LQA_P_FREQ_OFS:  return p.freq_ofs;
      LQA_P_FREQ_CTL:  return p.freq_ctl;
      LQA_P_VARIANCE:  return hi ? p.variance[31:24] : p.variance[23:16];
      default:         return 8'h00;
    endcase
  endfunction : lqa_live_byte

  // ==========================================================
  // decode
  assign wr_data = wr_i && (addr_i == LQA_ADDR_DATA);
  assign wr_var  = wr_i && (addr_i == LQA_ADDR_VARIANCE);
  assign rd_data = rd_i && (addr_i == LQA_ADDR_DATA);
  assign rd_var  = rd_i && (addr_i == LQA_ADDR_VARIANCE);
  assign rd_main = rd_i && (addr_i == LQA_ADDR_MAIN);
  assign active  = monitor_enable_i && link_100_ok_i;

  // the store sees the selects of this very write, so one write may set and commit
  assign commit = wr_data && wdata_i[LQA_COMMIT_BIT] && !power_down_i;

  lqa_thr_store u_store (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .wr_i       (commit),
    .psel_i     (wr_data ? wdata_i[LQA_PSEL_HI:LQA_PSEL_LO] : st.psel),
    .tsel_i     (wr_data ? wdata_i[LQA_TSEL_BIT] : st.tsel),
    .byte_i     (wdata_i[LQA_BYTE_HI:LQA_BYTE_LO]),
    .rd_byte_o  (thr_byte),
    .flat_o     (thr_flat)
  );

  lqa_compare u_cmp (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .active_i   (active),
    .params_i   (params_i),
    .thr_i      (thr_flat),
    .warn_o     (warn),
    .var_over_o (var_over)
  );

  // ==========================================================
  // next state
  always_comb begin
    logic var_event;
    logic any_event;
    var_event = var_over && !st.var_prev;
    any_event = (|warn) || var_over;
    next_st = st;
    next_st.restart  = 1'b0;
    next_st.drop     = 1'b0;
    next_st.rdata    = 16'h0000;
    next_st.var_prev = var_over;

    if (wr_data) begin
      next_st.psel      = wdata_i[LQA_PSEL_HI:LQA_PSEL_LO];
      next_st.tsel      = wdata_i[LQA_TSEL_BIT];
      next_st.sample_on = wdata_i[LQA_SAMPLE_BIT];
      next_st.data_byte = wdata_i[LQA_BYTE_HI:LQA_BYTE_LO];
      // a write with sampling on starts a new read sequence: capture once
      if (wdata_i[LQA_SAMPLE_BIT]) begin
        next_st.sampled = lqa_live_byte(wdata_i[LQA_PSEL_HI:LQA_PSEL_LO], params_i,
                                        wdata_i[LQA_TSEL_BIT]);
      end
    end
    if (wr_var) begin
      next_st.restart_var = wdata_i[LQA_RESTART_VAR_BIT];
    end

    // ---- read data, one cycle later
    if (rd_data) begin
      next_st.rdata[LQA_SAMPLE_BIT]              = st.sample_on;
      next_st.rdata[LQA_PSEL_HI:LQA_PSEL_LO]     = st.psel;
      next_st.rdata[LQA_TSEL_BIT]                = st.tsel;
      next_st.rdata[LQA_BYTE_HI:LQA_BYTE_LO]     = st.sample_on ? st.sampled
                                                                : thr_byte;
    end else if (rd_var) begin
      next_st.rdata[LQA_RESTART_VAR_BIT] = st.restart_var;
      next_st.rdata[LQA_VAR_FLAG_BIT]    = st.var_flag;
    end

    // ---- sticky warnings; a set in the clearing cycle survives
    if (rd_var) begin
      next_st.var_flag = 1'b0;
    end
    if (rd_main) begin
      next_st.main_warn = '0;
      next_st.armed     = 1'b1;
      next_st.irq       = 1'b0;
    end
    if (var_over) begin
      next_st.var_flag = 1'b1;
    end
    next_st.main_warn = next_st.main_warn | warn;

    // ---- interrupt fires once per arming
    if (any_event && st.armed && irq_enable_i) begin
      next_st.irq   = 1'b1;
      next_st.armed = 1'b0;
    end

    // ---- automatic restart on a new variance violation
    if (var_event && st.restart_var) begin
      next_st.restart = 1'b1;
      next_st.drop    = !signal_detect_option_i;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st           <= '0;
      st.data_byte <= LQA_BYTE_RESET;
      st.armed     <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o       = st.rdata;
  assign main_warn_o   = st.main_warn;
  assign irq_o         = st.irq;
  assign dsp_restart_o = st.restart;
  assign link_drop_o   = st.drop;

endmodule : lqa_access

//--- tb/lqa_access_properties.sv
// concurrent checks for the link quality access block, bound to its ports
// assumes one-cycle read latency and pulse outputs as handed over
module lqa_access_properties
  import lqa_pkg::*;
(
  input wire logic        core_clk_i,             // clock
  input wire logic        rstn_i,                 // reset, active low
  input wire logic [4:0]  addr_i,                 // address
  input wire logic [15:0] wdata_i,                // write data
  input wire logic        wr_i,                   // write strobe
  input wire logic        rd_i,                   // read strobe
  input wire logic [15:0] rdata_o,                // read data
  input wire logic        power_down_i,           // powered down
  input wire logic        monitor_enable_i,       // monitor enable
  input wire logic        link_100_ok_i,          // link present
  input wire logic        signal_detect_option_i, // option bit
  input wire logic        irq_enable_i,           // mask enable
  input wire lqa_params_t params_i,               // live values
  input wire logic [9:0]  main_warn_o,            // warnings
  input wire logic        irq_o,                  // interrupt
  input wire logic        dsp_restart_o,          // restart pulse
  input wire logic        link_drop_o             // link drop pulse
);
  // ==========================================
  // assertions
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  read_idle_zero_a: assert property (!$past(rd_i) |-> rdata_o == 16'h0)
    else $error("read data not idle");
  data_reserved_zero_a: assert property ($past(rd_i && addr_i == LQA_ADDR_DATA)
    |-> rdata_o[15:14] == 2'h0 && !rdata_o[12]) else $error("data register reserved bits set");
  var_reserved_zero_a: assert property ($past(rd_i && addr_i == LQA_ADDR_VARIANCE)
    |-> rdata_o[15:11] == 5'h0 && rdata_o[9:2] == 8'h0 && !rdata_o[0]) else $error("variance reserved set");
  unmapped_zero_a: assert property ($past(rd_i && addr_i < LQA_ADDR_MAIN) |-> rdata_o == 16'h0)
    else $error("unmapped read not zero");
  restart_pulse_a: assert property (dsp_restart_o |=> !dsp_restart_o)
    else $error("restart longer than one cycle");
  link_drop_pair_a: assert property (link_drop_o |-> dsp_restart_o)
    else $error("link drop without restart");
  irq_masked_a: assert property ($rose(irq_o) |-> $past(irq_enable_i))
    else $error("interrupt while masked");
  irq_clear_main_a: assert property ($fell(irq_o) |-> $past(rd_i && addr_i == LQA_ADDR_MAIN))
    else $error("interrupt cleared without main read");
  var_read_keeps_a: assert property (irq_o && rd_i && addr_i == LQA_ADDR_VARIANCE |=> irq_o)
    else $error("variance read cleared interrupt");
endmodule : lqa_access_properties

bind lqa_access lqa_access_properties lqa_access_properties_i (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .power_down_i(power_down_i), .monitor_enable_i(monitor_enable_i),
  .link_100_ok_i(link_100_ok_i), .signal_detect_option_i(signal_detect_option_i), .irq_enable_i(irq_enable_i),
  .params_i(params_i), .main_warn_o(main_warn_o), .irq_o(irq_o), .dsp_restart_o(dsp_restart_o),
  .link_drop_o(link_drop_o));

//--- tb/testbench.sv
// self-checking bench for the link quality access block
// assumes the strobe register port and the package field positions
module testbench
  import lqa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // signals
  logic        core_clk_i, rstn_i, wr_i, rd_i, pdown, mon_en, link_ok, sd_opt, irq_en, irq, restart, drop;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata;
  logic [9:0]  warn;
  lqa_params_t params;
  int          errors = 0;
  int          tests_run = 0;

  lqa_access lqa_access_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .power_down_i(pdown), .monitor_enable_i(mon_en),
    .link_100_ok_i(link_ok), .signal_detect_option_i(sd_opt), .irq_enable_i(irq_en), .params_i(params),
    .main_warn_o(warn), .irq_o(irq), .dsp_restart_o(restart), .link_drop_o(drop));

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  // ==========================================
  // helpers
  function automatic logic [15:0] dacc(logic s, logic c, logic [2:0] p, logic t, logic [7:0] b);
    return {2'h0, s, c, p, t, b};
  endfunction : dacc
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic bus_wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    addr <= a;
    wdata <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask : bus_wr
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] e, input string nm);
    @(posedge core_clk_i);
    addr <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 check(nm, rdata, e);
  endtask : rd_chk
  // ==========================================
  // scenarios
  task automatic t_thresholds;
    for (int p = 0; p < 6; p++) begin
      for (int t = 0; t < 2; t++) begin
        bus_wr(LQA_ADDR_DATA, dacc(1'b0, 1'b1, p[2:0], t[0], 8'h21 + 8'(p*2+t)));
      end
    end
    for (int p = 0; p < 6; p++) begin
      for (int t = 0; t < 2; t++) begin
        bus_wr(LQA_ADDR_DATA, dacc(1'b0, 1'b0, p[2:0], t[0], 8'h00));
        rd_chk(LQA_ADDR_DATA, dacc(1'b0, 1'b0, p[2:0], t[0], 8'h21 + 8'(p*2+t)), "thr");
      end
    end
  endtask : t_thresholds
  task automatic t_power_down;
    @(posedge core_clk_i);
    pdown <= 1'b1;
    bus_wr(LQA_ADDR_DATA, dacc(1'b0, 1'b1, 3'h0, 1'b0, 8'h33));
    pdown <= 1'b0;
    rd_chk(LQA_ADDR_DATA, dacc(1'b0, 1'b0, 3'h0, 1'b0, 8'h21), "pdown");
  endtask : t_power_down
  task automatic t_sample;
    bus_wr(LQA_ADDR_DATA, dacc(1'b1, 1'b0, 3'h1, 1'b0, 8'h00));
    params.gain <= 8'h66;
    rd_chk(LQA_ADDR_DATA, dacc(1'b1, 1'b0, 3'h1, 1'b0, 8'h5a), "sample");
    for (int t = 0; t < 2; t++) begin
      bus_wr(LQA_ADDR_DATA, dacc(1'b1, 1'b0, 3'h5, t[0], 8'h00));
      rd_chk(LQA_ADDR_DATA, dacc(1'b1, 1'b0, 3'h5, t[0], t ? 8'hc3 : 8'ha7), "var");
    end
    bus_wr(LQA_ADDR_DATA, 16'h0000);
  endtask : t_sample
  task automatic t_reserved;
    bus_wr(LQA_ADDR_VARIANCE, 16'hffff);
    rd_chk(LQA_ADDR_VARIANCE, 16'h0400, "var rsv");
    bus_wr(LQA_ADDR_DATA, 16'hc000 | dacc(1'b0, 1'b0, 3'h2, 1'b1, 8'h00));
    rd_chk(LQA_ADDR_DATA, dacc(1'b0, 1'b0, 3'h2, 1'b1, 8'h26), "data rsv");
    bus_wr(5'h05, 16'hffff);
    rd_chk(5'h05, 16'h0000, "unmapped");
  endtask : t_reserved
  task automatic t_variance;
    int n;
    @(posedge core_clk_i);
    sd_opt <= 1'b0;
    irq_en <= 1'b1;
    mon_en <= 1'b1;
    link_ok <= 1'b1;
    n = 0;
    while (restart !== 1'b1 && n < 20) begin
      @(posedge core_clk_i);
      #1 n++;
    end
    check("restart", {15'h0, restart}, 16'h1);
    check("drop", {15'h0, drop}, 16'h1);
    @(posedge core_clk_i);
    mon_en <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    rd_chk(LQA_ADDR_VARIANCE, 16'h0402, "var flag");
    rd_chk(LQA_ADDR_VARIANCE, 16'h0400, "var clear");
    check("irq kept", {15'h0, irq}, 16'h1);
    rd_chk(LQA_ADDR_MAIN, 16'h0000, "main read");
    check("irq clear", {15'h0, irq}, 16'h0);
    // second violation with the option set: restart again, but link must stay up
    @(posedge core_clk_i);
    irq_en <= 1'b0;
    sd_opt <= 1'b1;
    mon_en <= 1'b1;
    n = 0;
    while (restart !== 1'b1 && n < 20) begin
      @(posedge core_clk_i);
      #1 n++;
    end
    check("restart sd", {15'h0, restart}, 16'h1);
    check("no drop", {15'h0, drop}, 16'h0);
    repeat (8) @(posedge core_clk_i);
    #1 check("masked", {15'h0, irq}, 16'h0);
    check("warn", {6'h0, warn}, 16'h02a9);
  endtask : t_variance
  // ==========================================
  // run control
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  initial begin
    {rstn_i, wr_i, rd_i, pdown, mon_en, link_ok, sd_opt, irq_en} = 8'h00;
    addr = 5'h00;
    wdata = 16'h0000;
    params = {8'h11, 8'h5a, 8'h33, 8'h44, 8'h55, 32'hc3a7_1234};
    repeat (10) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    rd_chk(LQA_ADDR_DATA, 16'h0080, "reset");
    t_thresholds();
    t_power_down();
    t_sample();
    t_reserved();
    t_variance();
    final_report();
  end
  // the whole sequence needs well under 2000 cycles
  initial begin
    #200000;
    errors++;
    final_report();
  end
endmodule : testbench
